// *** design/cbf_flags.sv ***
// full/overflow flags for 32 buffers plus one buffer pair control register
// assumes store and transmit-end events come from logic on the same clock
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cbf_flags import cbf_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // engine events
  input wire cbf_store_type i_store,
  input wire cbf_tx_end_type i_tx_end,
  // flag and control state
  output logic [NUM_BUF-1:0] o_full_flags,
  output logic [NUM_BUF-1:0] o_overrun_flags,
  output logic [15:0] o_pair_control,
  output logic [1:0] o_direction
);
  logic [NUM_BUF-1:0] buffer_full_flag;
  logic [NUM_BUF-1:0] buffer_overrun_flag;
  logic [1:0][BYTE_W-1:0] pair_ctrl;
  logic dph_valid;
  logic dph_write;
  logic [ADDR_W-1:0] dph_addr;
  logic [NUM_BUF-1:0] store_hit;
  logic [NUM_BUF-1:0] full_clr;
  logic [NUM_BUF-1:0] ovf_clr;
  logic wr_ctrl;

  // set has priority over clear so no event is lost
  function automatic logic [NUM_BUF-1:0] next_flags(
    input logic [NUM_BUF-1:0] cur,
    input logic [NUM_BUF-1:0] set,
    input logic [NUM_BUF-1:0] clr);
    next_flags = (cur & ~clr) | set; // RQ12
  endfunction

  // zero bits of a write select flags to clear, one bits are ignored
  function automatic logic [NUM_BUF-1:0] clr_mask(
    input logic wr_lo,
    input logic wr_hi,
    input logic [31:0] wdata);
    clr_mask = {wr_hi ? ~wdata[HALF-1:0] : PAD_ZERO,
                wr_lo ? ~wdata[HALF-1:0] : PAD_ZERO}; // RQ3
  endfunction

  function automatic logic [BYTE_W-1:0] next_ctrl(
    input logic [BYTE_W-1:0] cur,
    input logic wr,
    input logic [BYTE_W-1:0] wdata,
    input logic ev,
    input cbf_tx_end_type tx);
    next_ctrl = cur;
    if (wr) begin
      // status bits are read-only from the bus
      next_ctrl = (wdata & CTRL_RW_MASK) | (cur & ~CTRL_RW_MASK); // RQ7
    end
    if (ev) begin
      next_ctrl[BIT_ABT] = tx.aborted; // RQ9
      next_ctrl[BIT_LARB] = tx.arb_lost; // RQ10
      next_ctrl[BIT_ERR] = tx.bus_error; // RQ11
      if (!tx.aborted && !tx.arb_lost && !tx.bus_error) begin
        next_ctrl[BIT_REQ] = 1'b0;
      end
    end
  endfunction

  // zero wait states: every transfer completes in its first data cycle
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= OFS_FULL_LO;
    end else if (i_hready) begin
      dph_valid <= i_hsel && i_htrans[HTRANS_ACT_BIT];
      dph_write <= i_hwrite;
      dph_addr <= i_haddr[ADDR_W-1:0];
    end
  end

  assign store_hit = i_store.valid ? (NUM_BUF'(1) << i_store.index) : '0;
  assign full_clr = clr_mask(dph_valid && dph_write && dph_addr == OFS_FULL_LO,
                             dph_valid && dph_write && dph_addr == OFS_FULL_HI,
                             i_hwdata);
  assign ovf_clr = clr_mask(dph_valid && dph_write && dph_addr == OFS_OVF_LO,
                            dph_valid && dph_write && dph_addr == OFS_OVF_HI,
                            i_hwdata);
  assign wr_ctrl = dph_valid && dph_write && dph_addr == OFS_PAIR_CTRL;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      buffer_full_flag <= FLAGS_RST; // RQ6
    end else begin
      buffer_full_flag <= next_flags(buffer_full_flag, store_hit,
                                     full_clr); // RQ1
    end
  end

  // an overrun is only a store landing on a buffer already marked full
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      buffer_overrun_flag <= FLAGS_RST; // RQ6
    end else begin
      buffer_overrun_flag <= next_flags(buffer_overrun_flag,
                                        store_hit & buffer_full_flag,
                                        ovf_clr); // RQ4
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pair_ctrl <= {CTRL_BYTE_RST, CTRL_BYTE_RST};
    end else begin
      for (int s = 0; s < 2; s++) begin
        pair_ctrl[s] <= next_ctrl(pair_ctrl[s], wr_ctrl,
                                  i_hwdata[s*BYTE_W +: BYTE_W],
                                  i_tx_end.valid && i_tx_end.slot == s[0],
                                  i_tx_end); // RQ7
      end
    end
  end

  // read mux over flops; unmapped offsets read zero
  always_comb begin
    o_hrdata = '0;
    if (dph_valid && !dph_write) begin
      unique case (dph_addr)
        OFS_FULL_LO: o_hrdata = {PAD_ZERO, buffer_full_flag[HALF-1:0]}; // RQ3
        OFS_FULL_HI: // RQ2
          o_hrdata = {PAD_ZERO, buffer_full_flag[NUM_BUF-1:HALF]};
        OFS_OVF_LO: // RQ5
          o_hrdata = {PAD_ZERO, buffer_overrun_flag[HALF-1:0]};
        OFS_OVF_HI: // RQ5
          o_hrdata = {PAD_ZERO, buffer_overrun_flag[NUM_BUF-1:HALF]};
        OFS_PAIR_CTRL: o_hrdata = {PAD_ZERO, pair_ctrl};
        default: o_hrdata = '0;
      endcase
    end
  end

  assign o_full_flags = buffer_full_flag;
  assign o_overrun_flags = buffer_overrun_flag;
  assign o_pair_control = pair_ctrl;
  assign o_direction = {pair_ctrl[1][BIT_DIR], pair_ctrl[0][BIT_DIR]}; // RQ8

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  full_set_a: assert property ( // RQ1
    i_store.valid |=> buffer_full_flag[$past(i_store.index)])
    else $error("store did not set full flag");
  ovf_set_a: assert property ( // RQ4
    i_store.valid && buffer_full_flag[i_store.index]
      |=> buffer_overrun_flag[$past(i_store.index)])
    else $error("store into full buffer did not set overflow");
  ovf_cause_a: assert property ( // RQ6
    (buffer_overrun_flag & ~$past(buffer_overrun_flag)) != '0
      |-> $past(i_store.valid))
    else $error("overflow flag rose without a store");
  clear_zero_a: assert property ( // RQ3
    dph_valid && dph_write && dph_addr == OFS_FULL_LO &&
      i_hwdata[HALF-1:0] == PAD_ZERO && !i_store.valid
      |=> buffer_full_flag[HALF-1:0] == PAD_ZERO)
    else $error("writing zero did not clear full flags");
  write_one_keep_a: assert property ( // RQ3
    dph_valid && dph_write && dph_addr == OFS_OVF_HI &&
      i_hwdata[HALF-1:0] == ~PAD_ZERO
      |=> ($past(buffer_overrun_flag[NUM_BUF-1:HALF]) &
           ~buffer_overrun_flag[NUM_BUF-1:HALF]) == PAD_ZERO)
    else $error("writing one changed overflow flags");
  set_wins_a: assert property ( // RQ12
    i_store.valid && full_clr[i_store.index]
      |=> buffer_full_flag[$past(i_store.index)])
    else $error("clear beat a same-cycle set");
  read_high_a: assert property ( // RQ2
    i_hready && i_hsel && i_htrans[HTRANS_ACT_BIT] && !i_hwrite &&
      i_haddr[ADDR_W-1:0] == OFS_FULL_HI
      |=> o_hrdata == {PAD_ZERO, buffer_full_flag[NUM_BUF-1:HALF]})
    else $error("full high register read back wrong");
  read_ovf_a: assert property ( // RQ5
    i_hready && i_hsel && i_htrans[HTRANS_ACT_BIT] && !i_hwrite &&
      i_haddr[ADDR_W-1:0] == OFS_OVF_LO
      |=> o_hrdata == {PAD_ZERO, buffer_overrun_flag[HALF-1:0]})
    else $error("overflow low register read back wrong");
  status_ro_a: assert property ( // RQ7
    wr_ctrl && !i_tx_end.valid |=> $stable(pair_ctrl[0][BIT_ABT:BIT_ERR])
      && $stable(pair_ctrl[1][BIT_ABT:BIT_ERR]))
    else $error("bus write changed a read-only status bit");
  direction_a: assert property ( // RQ8
    wr_ctrl |=> o_direction ==
      {$past(i_hwdata[BYTE_W+BIT_DIR]), $past(i_hwdata[BIT_DIR])})
    else $error("direction did not follow control write");
  abort_a: assert property ( // RQ9
    i_tx_end.valid |=> pair_ctrl[$past(i_tx_end.slot)][BIT_ABT] ==
      $past(i_tx_end.aborted))
    else $error("abort status wrong after transmit end");
  arb_lost_a: assert property ( // RQ10
    i_tx_end.valid |=> pair_ctrl[$past(i_tx_end.slot)][BIT_LARB] ==
      $past(i_tx_end.arb_lost))
    else $error("arbitration status wrong after transmit end");
  send_err_a: assert property ( // RQ11
    i_tx_end.valid |=> pair_ctrl[$past(i_tx_end.slot)][BIT_ERR] ==
      $past(i_tx_end.bus_error))
    else $error("error status wrong after transmit end");

  overrun_seen_c: cover property (
    i_store.valid && buffer_full_flag[i_store.index]);
  set_clear_race_c: cover property (
    i_store.valid && full_clr[i_store.index]);
  ctrl_write_c: cover property (wr_ctrl ##1 i_tx_end.valid);
endmodule
`default_nettype wire

// *** design/cbf_pkg.sv ***
// constants, field positions and carrier types for the buffer status flags
// assumes a single 250 MHz clock and an AHB-Lite register bus
// Operation
// RQ1: a message stored into a buffer sets that buffer's full flag.
// RQ2: 32 full flags sit in two 16-bit registers, buffer 16 at bit 0 of the high one.
// RQ3: software clears a full or overflow flag only by writing zero, writing one keeps it, reads show it.
// RQ4: storing into a buffer whose full flag is set sets that buffer's overflow flag.
// RQ5: 32 overflow flags sit in two 16-bit registers, buffer number equal to bit position; the code puts buffer 16 at bit 0 of the high one.
// RQ6: an overflow flag at zero means no overflow was seen, and all flags reset to zero.
// RQ7: one 16-bit control register serves a buffer pair, one byte each, abort, arbitration and error bits read-only.
// RQ8: the direction bit makes its buffer a transmit buffer at one, a receive buffer at zero.
// RQ9: the abort status bit is set when sending was aborted and cleared when it completed.
// RQ10: the arbitration lost bit is set when the message lost arbitration, clear otherwise.
// RQ11: the send error bit is set when a bus error hit the message, clear otherwise.
// RQ12: a hardware set in the same cycle as a software clear wins.
package cbf_pkg;
  localparam int NUM_BUF = 32;
  localparam int HALF = 16;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 8;
  localparam int HTRANS_ACT_BIT = 1;

  localparam logic [ADDR_W-1:0] OFS_FULL_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FULL_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OVF_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OVF_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PAIR_CTRL = 8'h10;

  localparam logic [NUM_BUF-1:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] CTRL_BYTE_RST = 8'h00;
  localparam logic [15:0] PAD_ZERO = 16'h0000;

  // bit positions inside one control byte
  localparam int BIT_DIR = 7;
  localparam int BIT_ABT = 6;
  localparam int BIT_LARB = 5;
  localparam int BIT_ERR = 4;
  localparam int BIT_REQ = 3;
  localparam logic [BYTE_W-1:0] CTRL_RW_MASK = 8'h8f;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
  } cbf_store_type;

  typedef struct packed {
    logic valid;
    logic slot;
    logic aborted;
    logic arb_lost;
    logic bus_error;
  } cbf_tx_end_type;
endpackage

// *** tb/test_can_buffer_status_flags.sv ***
// self-checking bench for the buffer flag and pair control logic
// assumes the single-slave ahb-lite hookup, hready fed from hreadyout
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module test_can_buffer_status_flags import cbf_pkg::*;;
  localparam logic [7:0] FLAG_OFS [4] = '{OFS_FULL_LO, OFS_FULL_HI,
    OFS_OVF_LO, OFS_OVF_HI};
  logic ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, rd_ph = 1'b0;
  logic [31:0] full_flags, ovr_flags;
  logic [15:0] pair_ctl;
  logic [1:0] dir;
  cbf_store_type st = '0;
  cbf_tx_end_type te = '0;
  // model: overflow flags above full flags
  logic [63:0] fl = '0;
  logic [15:0] ctrl = '0;
  logic [31:0] exp_q[$], ev;
  string name_q[$], en;
  int failures = 0, checked = 0;

  always #2 ref_clk = ~ref_clk;

  cbf_flags cbf_flags_inst (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_store(st), .i_tx_end(te), .o_full_flags(full_flags),
    .o_overrun_flags(ovr_flags), .o_pair_control(pair_ctl),
    .o_direction(dir));

  // read data is only meaningful at the edge that closes its data phase
  always @(posedge ref_clk) begin
    if (rd_ph && hreadyout) begin
      ev = exp_q.pop_front();
      en = name_q.pop_front();
      `CHK(en, ev, hrdata)
    end
  end

  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic addr_ph(input logic [7:0] a, input logic w);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_ph(a, 1'b1);
    hwdata <= {16'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    addr_ph(a, 1'b0);
    exp_q.push_back(e);
    name_q.push_back(nm);
    rd_ph <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic store(input logic [4:0] i);
    @(posedge ref_clk);
    st <= {1'b1, i};
    fl[32 + i] = fl[32 + i] | fl[i];
    fl[i] = 1'b1;
    @(posedge ref_clk);
    st <= '0;
  endtask

  task automatic txe(input logic s, input logic [2:0] c);
    @(posedge ref_clk);
    te <= {1'b1, s, c};
    ctrl[s*8+4 +: 3] = c;
    if (c == 3'b000) ctrl[s*8+3] = 1'b0;
    @(posedge ref_clk);
    te <= '0;
  endtask

  task automatic wctl(input logic [15:0] d);
    wr(OFS_PAIR_CTRL, d);
    ctrl = (ctrl & ~{2{CTRL_RW_MASK}}) | (d & {2{CTRL_RW_MASK}});
  endtask

  task automatic clr(input int r, input logic [15:0] d);
    wr(FLAG_OFS[r], d);
    fl[r*16 +: 16] = fl[r*16 +: 16] & d;
  endtask

  task automatic chkall;
    // look at the standing outputs away from the edge that updates them
    @(negedge ref_clk);
    `CHK("full_flags", fl[31:0], full_flags)
    `CHK("overrun_flags", fl[63:32], ovr_flags)
    `CHK("pair_control_out", ctrl, pair_ctl)
    `CHK("direction", {ctrl[15], ctrl[7]}, dir)
    `CHK("hresp", 1'b0, hresp)
    for (int r = 0; r < 4; r++)
      rd(FLAG_OFS[r], {16'h0, fl[r*16 +: 16]}, $sformatf("flags%0d", r));
    rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "pair_control");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h2c4c));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    chkall();
    wr(8'h14, 16'hffff);
    rd(8'h14, 32'h0, "unmapped");
    repeat (40) store(5'($urandom_range(31, 0)));
    store(5'd0);
    store(5'd0);
    store(5'd31);
    store(5'd31);
    chkall();
    // writing ones must leave every flag as it was
    for (int r = 0; r < 4; r++) clr(r, 16'hffff);
    chkall();
    for (int r = 0; r < 4; r++) clr(r, 16'($urandom));
    clr(0, 16'h0000);
    chkall();
    // store into full buffer 5 while software clears the same register
    store(5'd5);
    for (int r = 0; r < 4; r += 2) begin
      fork
        wr(FLAG_OFS[r], 16'h0000);
        begin
          @(posedge ref_clk);
          store(5'd5);
        end
      join
      fl[r*16 +: 16] = fl[r*16 +: 16] & 16'h0020;
    end
    chkall();
    wctl(16'hffff);
    rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "pair_control");
    for (int s = 0; s < 2; s++) begin
      txe(s[0], 3'b100);
      rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "aborted");
      txe(s[0], 3'b010);
      rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "arb_lost");
      txe(s[0], 3'b001);
      rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "bus_error");
      txe(s[0], 3'b000);
      rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "sent_ok");
      txe(s[0], 3'b111);
    end
    repeat (4) begin
      wctl(16'($urandom));
      rd(OFS_PAIR_CTRL, {16'h0, ctrl}, "pair_control");
    end
    summarize();
  end
endmodule
`default_nettype wire
